// ### dv/sem_host.sv
// Host model for status commands
`timescale 1ns/1ps
module sem_host (input wire logic i_core_clk, i_rsp_valid, output logic [21:0] o_cmd = '0);
   task automatic cmd(input logic [20:0] c);
      @(posedge i_core_clk) #1 o_cmd = {1'b1, c};
      @(posedge i_core_clk) #1 o_cmd = '0;
      for (int n = 0; n < 9 && i_rsp_valid !== 1'b1; n++) @(posedge i_core_clk) #1;
   endtask
endmodule

// ### dv/tb_sem_status_core.sv
// Status block testbench
`timescale 1ns/1ps
module tb_sem_status_core;
   logic i_core_clk = 0, i_rst = 1;
   logic o_rsp_valid, o_meas_summary, o_ques_summary, o_oper_summary;
   logic [15:0] i_meas_cond = '1, i_ques_cond = '1, i_oper_cond = '1, o_rsp_data, r;
   logic [21:0] c;
   int miscompares = 0, samples_checked = 0, cyc = 0;
   always #5 i_core_clk = ~i_core_clk;
   sem_status_core u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd_valid(c[21]),
      .i_cmd_op(c[20:18]), .i_cmd_group(c[17:16]), .i_cmd_data(c[15:0]),
      .i_meas_cond(i_meas_cond), .i_ques_cond(i_ques_cond), .i_oper_cond(i_oper_cond),
      .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data), .o_meas_summary(o_meas_summary),
      .o_ques_summary(o_ques_summary), .o_oper_summary(o_oper_summary));
   sem_host u_host (.i_core_clk(i_core_clk), .i_rsp_valid(o_rsp_valid), .o_cmd(c));
   task automatic q(input logic [2:0] o, logic [1:0] g, logic [15:0] e);
      if (o != 0) u_host.cmd({o, g, e});
      if (o != 0 && o_rsp_valid !== 1'b1) begin
         miscompares++;
         $display("unexpected %0t %h %h", $time, o_rsp_valid, 1'b1);
      end
      r = (o != 0) ? o_rsp_data : {13'h0, o_meas_summary, o_ques_summary, o_oper_summary};
      if (o[1:0] != 2'h1) begin
         samples_checked++;
         if (r !== e) begin
            miscompares++;
            $display("unexpected %0t %h %h", $time, r, e);
         end
      end
   endtask
   task automatic close_out();
      $display("counts %0d %0d", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge i_core_clk) if (++cyc == 900) begin miscompares++; close_out(); end
   initial begin
      #201 i_rst = 0;
      q(sem_pkg::OP_WR_MASK, sem_pkg::GRP_MEAS, 16'h4400);
      i_meas_cond = '0;
      q(0, 0, 16'h0004);
      q(sem_pkg::OP_RD_MASK, sem_pkg::GRP_MEAS, 16'h4000);
      q(sem_pkg::OP_RD_EVT, sem_pkg::GRP_MEAS, 16'h7BBF);
      q(sem_pkg::OP_RD_EVT, sem_pkg::GRP_MEAS, 16'h0000);
      q(sem_pkg::OP_RD_COND, sem_pkg::GRP_MEAS, 16'h0000);
      q(sem_pkg::OP_RD_COND, sem_pkg::GRP_QUES, 16'h4110);
      q(sem_pkg::OP_WR_MASK, sem_pkg::GRP_OPER, 16'hFFFF);
      q(sem_pkg::OP_RD_MASK, sem_pkg::GRP_OPER, 16'h0430);
      q(0, 0, 16'h0001);
      q(sem_pkg::OP_PRESET, 0, 0);
      q(sem_pkg::OP_RD_MASK, sem_pkg::GRP_MEAS, 16'h0000);
      q(sem_pkg::OP_RD_MASK, sem_pkg::GRP_OPER, 16'h0000);
      q(0, 0, 16'h0000);
      close_out();
   end
endmodule

// ### rtl/sem_pkg.sv
// Constants and state type for the status event mask and summary block
// Overview of operation
// RULE_01: Three independent 16-bit enable masks: measurement, questionable, operation.
// RULE_02: Mask write value sets each bit by its binary form; 0 clears, 65535 sets.
// RULE_03: Host sums bit weights, bit n weighing two to the power n.
// RULE_04: A cleared mask bit blocks its event bit from the group summary.
// RULE_05: A set mask bit with its event bit set asserts the group summary.
// RULE_06: Measurement bits 0 to 4: over range, lower and upper bounds one and two.
// RULE_07: Measurement bit 5 reading ready, bits 7 to 9 trace store; 6, 10, 15 unused.
// RULE_08: Measurement bits 11 to 14: under range, frequency high, low, shaping filter fault.
// RULE_09: Questionable bits 4, 8, 14 used; others unused; bit 15 reads 0.
// RULE_10: Operation bits 4 measuring, 5 triggering, 10 idle; others unused.
// RULE_11: Each group has a condition register laid out like its event register.
// RULE_12: Condition register never latches; follows present state every clock.
// RULE_13: Condition query returns the 16-bit condition content.
// RULE_14: Event query returns latched bits then clears that event register.
// RULE_15: Preset clears all three masks and leaves other registers alone.
// RULE_16: Event bit sets when its condition asserts and holds until read.
// RULE_17: Group summary is OR of event AND mask, every clock.
// RULE_18: Unused bits read zero and never reach the summary.
package sem_pkg;

   localparam int NUM_GROUPS = 3;

   localparam logic [1:0] GRP_MEAS = 2'h0;
   localparam logic [1:0] GRP_QUES = 2'h1;
   localparam logic [1:0] GRP_OPER = 2'h2;

   localparam logic [2:0] OP_WR_MASK = 3'h1;
   localparam logic [2:0] OP_RD_MASK = 3'h2;
   localparam logic [2:0] OP_RD_COND = 3'h3;
   localparam logic [2:0] OP_RD_EVT = 3'h4;
   localparam logic [2:0] OP_PRESET = 3'h5;

   // Measurement group bit positions
   localparam int BIT_READING_OVER_RANGE = 0;
   localparam int BIT_BELOW_LOWER_BOUND_ONE = 1;
   localparam int BIT_ABOVE_UPPER_BOUND_ONE = 2;
   localparam int BIT_BELOW_LOWER_BOUND_TWO = 3;
   localparam int BIT_ABOVE_UPPER_BOUND_TWO = 4;
   localparam int BIT_NEW_READING_READY = 5;
   localparam int BIT_TRACE_STORE_HAS_READINGS = 7;
   localparam int BIT_TRACE_STORE_HALF = 8;
   localparam int BIT_TRACE_STORE_COMPLETE = 9;
   localparam int BIT_READING_UNDER_RANGE = 11;
   localparam int BIT_DISTORTION_FREQ_TOO_HIGH = 12;
   localparam int BIT_DISTORTION_FREQ_TOO_LOW = 13;
   localparam int BIT_SHAPING_FILTER_FAULT = 14;

   // Questionable group bit positions
   localparam int BIT_JUNCTION_FAULT = 4;
   localparam int BIT_BAD_CAL_CONSTANT = 8;
   localparam int BIT_PARAM_IGNORED = 14;

   // Operation group bit positions
   localparam int BIT_MEASURING = 4;
   localparam int BIT_TRIGGERING = 5;
   localparam int BIT_IDLE = 10;

   localparam logic [15:0] USED_MEAS = 16'h7BBF;
   localparam logic [15:0] USED_QUES = 16'h4110;
   localparam logic [15:0] USED_OPER = 16'h0430;

   localparam logic [15:0] MASK_RESET = 16'h0000;
   localparam logic [15:0] EVT_RESET = 16'h0000;
   localparam logic [15:0] COND_RESET = 16'h0000;
   localparam logic [15:0] RSP_RESET = 16'h0000;

   typedef struct packed {
      logic [NUM_GROUPS-1:0][15:0] mask;
      logic [NUM_GROUPS-1:0][15:0] evt;
      logic [NUM_GROUPS-1:0][15:0] cond;
      logic rsp_valid;
      logic [15:0] rsp_data;
   } sem_state_t;

endpackage

// ### rtl/sem_status_core.sv
// Status condition, event and enable mask registers with group summaries
`timescale 1ns/1ps
module sem_status_core (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_cmd_valid,
   input wire logic [2:0] i_cmd_op,
   input wire logic [1:0] i_cmd_group,
   input wire logic [15:0] i_cmd_data,
   input wire logic [15:0] i_meas_cond,
   input wire logic [15:0] i_ques_cond,
   input wire logic [15:0] i_oper_cond,
   output logic o_rsp_valid,
   output logic [15:0] o_rsp_data,
   output logic o_meas_summary,
   output logic o_ques_summary,
   output logic o_oper_summary
);

   // Registered state: masks, events, conditions and the query response
   sem_pkg::sem_state_t state;
   sem_pkg::sem_state_t next_state;

   logic [sem_pkg::NUM_GROUPS-1:0][15:0] cond_in;
   logic [sem_pkg::NUM_GROUPS-1:0][15:0] rise;
   logic [sem_pkg::NUM_GROUPS-1:0] rd_evt_hit;
   logic [sem_pkg::NUM_GROUPS-1:0] wr_mask_hit;
   logic [sem_pkg::NUM_GROUPS-1:0] summary;
   logic preset_hit;

   // Implemented bit positions of a group
   function automatic logic [15:0] used_bits(
      input logic [1:0] grp
   );
      logic [15:0] bits;
      bits = 16'h0000;
      case (grp)
         sem_pkg::GRP_MEAS: begin
            bits = sem_pkg::USED_MEAS;  // RULE_06 RULE_07 RULE_08
         end
         sem_pkg::GRP_QUES: begin
            bits = sem_pkg::USED_QUES;  // RULE_09
         end
         sem_pkg::GRP_OPER: begin
            bits = sem_pkg::USED_OPER;  // RULE_10
         end
         default: begin
            bits = 16'h0000;
         end
      endcase
      return bits;
   endfunction

   // Command decode for one operation on one group
   function automatic logic cmd_hit(
      input logic valid,
      input logic [2:0] op,
      input logic [1:0] grp,
      input logic [2:0] op_want,
      input logic [1:0] grp_want
   );
      logic hit;
      hit = 1'b0;
      if (valid && (op == op_want) && (grp == grp_want)) begin
         hit = 1'b1;
      end
      return hit;
   endfunction

   // Pick one group's word; an unknown group answers zero
   function automatic logic [15:0] pick_group(
      input logic [sem_pkg::NUM_GROUPS-1:0][15:0] regs,
      input logic [1:0] grp
   );
      logic [15:0] word;
      word = 16'h0000;
      case (grp)
         sem_pkg::GRP_MEAS: begin
            word = regs[sem_pkg::GRP_MEAS];
         end
         sem_pkg::GRP_QUES: begin
            word = regs[sem_pkg::GRP_QUES];
         end
         sem_pkg::GRP_OPER: begin
            word = regs[sem_pkg::GRP_OPER];
         end
         default: begin
            word = 16'h0000;
         end
      endcase
      return word;
   endfunction

   // Live condition inputs, unused positions forced low
   assign cond_in[sem_pkg::GRP_MEAS] = i_meas_cond & sem_pkg::USED_MEAS;  // RULE_11 RULE_18
   assign cond_in[sem_pkg::GRP_QUES] = i_ques_cond & sem_pkg::USED_QUES;  // RULE_11 RULE_18
   assign cond_in[sem_pkg::GRP_OPER] = i_oper_cond & sem_pkg::USED_OPER;  // RULE_11 RULE_18

   assign preset_hit = i_cmd_valid && (i_cmd_op == sem_pkg::OP_PRESET);

   // Per group decode, event edge and summary
   genvar g;
   generate
      for (g = 0; g < sem_pkg::NUM_GROUPS; g++) begin : gen_group
         assign rise[g] = cond_in[g] & ~state.cond[g];  // RULE_16
         assign rd_evt_hit[g] = cmd_hit(
            i_cmd_valid,
            i_cmd_op,
            i_cmd_group,
            sem_pkg::OP_RD_EVT,
            2'(g)
         );
         assign wr_mask_hit[g] = cmd_hit(
            i_cmd_valid,
            i_cmd_op,
            i_cmd_group,
            sem_pkg::OP_WR_MASK,
            2'(g)
         );
         assign summary[g] = |(state.evt[g] & state.mask[g]);  // RULE_04 RULE_05 RULE_17

         a_event_holds_set: assert property (  // RULE_16
            @(posedge i_core_clk) disable iff (i_rst)
            !rd_evt_hit[g]
            |=> ((state.evt[g] & $past(state.evt[g])) == $past(state.evt[g]))
         ) else $error("event bit dropped without a read");

         a_masked_summary_low: assert property (  // RULE_04
            @(posedge i_core_clk) disable iff (i_rst)
            ((state.evt[g] & state.mask[g]) == 16'h0000)
            |-> !summary[g]
         ) else $error("masked event reached the summary");
      end
   endgenerate

   // Next state
   always_comb begin
      next_state = state;
      next_state.rsp_valid = 1'b0;
      next_state.rsp_data = sem_pkg::RSP_RESET;
      for (int k = 0; k < sem_pkg::NUM_GROUPS; k++) begin
         next_state.cond[k] = cond_in[k];  // RULE_12
         if (rd_evt_hit[k]) begin
            next_state.evt[k] = rise[k];  // RULE_14
         end
         else begin
            next_state.evt[k] = state.evt[k] | rise[k];  // RULE_16
         end
         if (preset_hit) begin
            next_state.mask[k] = sem_pkg::MASK_RESET;  // RULE_15
         end
         else if (wr_mask_hit[k]) begin
            next_state.mask[k] = i_cmd_data & used_bits(2'(k));  // RULE_01 RULE_02 RULE_18
         end
      end
      if (i_cmd_valid) begin
         next_state.rsp_valid = 1'b1;
         case (i_cmd_op)
            sem_pkg::OP_RD_MASK: begin
               next_state.rsp_data = pick_group(state.mask, i_cmd_group);  // RULE_01
            end
            sem_pkg::OP_RD_COND: begin
               next_state.rsp_data = pick_group(state.cond, i_cmd_group);  // RULE_13
            end
            sem_pkg::OP_RD_EVT: begin
               next_state.rsp_data = pick_group(state.evt, i_cmd_group);  // RULE_14
            end
            default: begin
               next_state.rsp_data = sem_pkg::RSP_RESET;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         state.mask <= {sem_pkg::NUM_GROUPS{sem_pkg::MASK_RESET}};
         state.evt <= {sem_pkg::NUM_GROUPS{sem_pkg::EVT_RESET}};
         state.cond <= {sem_pkg::NUM_GROUPS{sem_pkg::COND_RESET}};
         state.rsp_valid <= 1'b0;
         state.rsp_data <= sem_pkg::RSP_RESET;
      end
      else begin
         state <= next_state;
      end
   end

   assign o_rsp_valid = state.rsp_valid;
   assign o_rsp_data = state.rsp_data;
   assign o_meas_summary = summary[sem_pkg::GRP_MEAS];  // RULE_17
   assign o_ques_summary = summary[sem_pkg::GRP_QUES];  // RULE_17
   assign o_oper_summary = summary[sem_pkg::GRP_OPER];  // RULE_17

   a_mask_write_lands: assert property (  // RULE_02
      @(posedge i_core_clk) disable iff (i_rst)
      wr_mask_hit[sem_pkg::GRP_MEAS] && !preset_hit
      |=> (state.mask[sem_pkg::GRP_MEAS] == ($past(i_cmd_data) & sem_pkg::USED_MEAS))
   ) else $error("mask write did not land");

   a_preset_clears_masks: assert property (  // RULE_15
      @(posedge i_core_clk) disable iff (i_rst)
      preset_hit
      |=> (state.mask == {sem_pkg::NUM_GROUPS{sem_pkg::MASK_RESET}})
   ) else $error("preset left a mask bit set");

   a_event_read_clears: assert property (  // RULE_14
      @(posedge i_core_clk) disable iff (i_rst)
      rd_evt_hit[sem_pkg::GRP_MEAS] && (rise[sem_pkg::GRP_MEAS] == 16'h0000)
      |=> o_rsp_valid
         && (o_rsp_data == $past(state.evt[sem_pkg::GRP_MEAS]))
         && (state.evt[sem_pkg::GRP_MEAS] == 16'h0000)
   ) else $error("event read did not answer and clear");

   a_cond_tracks_input: assert property (  // RULE_12
      @(posedge i_core_clk) disable iff (i_rst)
      1'b1
      |=> (state.cond[sem_pkg::GRP_MEAS] == ($past(i_meas_cond) & sem_pkg::USED_MEAS))
   ) else $error("condition register did not follow its input");

   a_unused_bits_zero: assert property (  // RULE_18
      @(posedge i_core_clk) disable iff (i_rst)
      ((state.evt[sem_pkg::GRP_QUES] & ~sem_pkg::USED_QUES) == 16'h0000)
         && ((state.mask[sem_pkg::GRP_QUES] & ~sem_pkg::USED_QUES) == 16'h0000)
         && ((state.evt[sem_pkg::GRP_OPER] & ~sem_pkg::USED_OPER) == 16'h0000)
         && ((state.mask[sem_pkg::GRP_OPER] & ~sem_pkg::USED_OPER) == 16'h0000)
   ) else $error("unused bit position is set");

   a_enabled_summary_high: assert property (  // RULE_05
      @(posedge i_core_clk) disable iff (i_rst)
      ((state.evt[sem_pkg::GRP_MEAS] & state.mask[sem_pkg::GRP_MEAS]) != 16'h0000)
      |-> o_meas_summary
   ) else $error("enabled event did not raise the summary");

endmodule
